// ---- chc_pkg.sv ----
// Shared constants and types for the charge and discharge counter core.
// Assumes a 10 MHz core clock; every time below is turned into cycles here.
package chc_pkg;

  typedef logic [39:0] chc_long_t;
  typedef enum logic {PWR_NORMAL = 1'b0, PWR_SLEEP = 1'b1} chc_pwr_e;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_BIT = 2'b10} chc_tx_e;

  localparam int CLK_MHZ = 10;

  // Link timing, microseconds
  localparam int T_BIT_US      = 205;
  localparam int T_START_US    = 40;
  localparam int T_ZERO_US     = 145;
  localparam int T_SAMPLE_US   = 100;
  localparam int T_BREAK_US    = 190;
  localparam int T_RSP_US      = 250;
  localparam int T_RSP_MIN_US  = 190;
  localparam int T_RSP_MAX_US  = 320;
  localparam int T_CYC_MIN_US  = 190;
  localparam int T_CYC_MAX_US  = 250;
  localparam int T_STRB_MIN_US = 32;

  localparam logic [11:0] CYC_BIT    = 12'(T_BIT_US * CLK_MHZ);
  localparam logic [11:0] CYC_START  = 12'(T_START_US * CLK_MHZ);
  localparam logic [11:0] CYC_ZERO   = 12'(T_ZERO_US * CLK_MHZ);
  localparam logic [11:0] CYC_SAMPLE = 12'(T_SAMPLE_US * CLK_MHZ);
  localparam logic [11:0] CYC_BREAK  = 12'(T_BREAK_US * CLK_MHZ);
  localparam logic [11:0] CYC_RSP    = 12'(T_RSP_US * CLK_MHZ);
  localparam int CYC_RSP_MIN  = T_RSP_MIN_US * CLK_MHZ;
  localparam int CYC_RSP_MAX  = T_RSP_MAX_US * CLK_MHZ;
  localparam int CYC_CYC_MIN  = T_CYC_MIN_US * CLK_MHZ;
  localparam int CYC_CYC_MAX  = T_CYC_MAX_US * CLK_MHZ;
  localparam int CYC_STRB_MIN = T_STRB_MIN_US * CLK_MHZ;

  // Long periods, seconds
  localparam real T_SLEEP_S = 10.0;
  localparam real T_FAST_S  = 0.8789;
  localparam real T_SLOW_S  = 225.0;
  localparam real T_HOUR_S  = 3600.0;
  localparam chc_long_t CYC_SLEEP = chc_long_t'(longint'(T_SLEEP_S * 1.0e6 * CLK_MHZ));
  localparam chc_long_t CYC_FAST  = chc_long_t'(longint'(T_FAST_S * 1.0e6 * CLK_MHZ));
  localparam chc_long_t CYC_SLOW  = chc_long_t'(longint'(T_SLOW_S * 1.0e6 * CLK_MHZ));
  localparam chc_long_t CYC_HOUR  = chc_long_t'(longint'(T_HOUR_S * 1.0e6 * CLK_MHZ));
  // Temperature code of the 20 to 30 degree step, where the rate is one per hour
  localparam logic [2:0] TEMP_NOMINAL = 3'h3;
  localparam chc_long_t CYC_SD_BASE = CYC_HOUR << TEMP_NOMINAL;
  localparam chc_long_t LONG_ONE  = 40'h00_0000_0001;
  localparam chc_long_t LONG_ZERO = 40'h00_0000_0000;

  // Register map, byte addresses on the link
  localparam logic [6:0] ADDR_OFFSET   = 7'h0A;
  localparam logic [6:0] ADDR_MODE     = 7'h0B;
  localparam int         CMD_WRITE_BIT = 7;
  localparam int         NUM_WORDS     = 5;
  localparam int         DIR_DCH       = 0;
  localparam int         DIR_CHG       = 1;
  localparam int         FIFO_DEPTH    = 16;

  // Values after reset
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [7:0]  SYNC_RST = 8'h01;

endpackage

// ---- chc_stream_if.sv ----
// Valid/ready byte stream between the receiver, the FIFO and the decoder.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface chc_stream_if #(parameter int W = 8) ();
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ---- chc_fifo.sv ----
// Synchronous FIFO of received link bytes ahead of the command decoder.
// Assumes one clock and an active-high reset already synchronised.
`timescale 1ns/1ns
`default_nettype none
module chc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic  clk,
  input wire logic  rst,
  // Streams
  chc_stream_if.snk wr,
  chc_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp;
  logic [AW:0]      rp;
  logic [AW:0]      next_wp;
  logic [AW:0]      next_rp;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign empty    = (wp == rp);
  assign full     = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rp[AW-1:0]];
  assign push     = wr.valid && !full;
  assign pop      = rd.ready && !empty;

  always_comb begin
    next_wp = wp;
    next_rp = rp;
    if (push) next_wp = wp + 1'b1;
    if (pop) next_rp = rp + 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
  end

  // Storage needs no reset; only pointers define what is valid
  always_ff @(posedge clk) begin
    if (push) mem[wp[AW-1:0]] <= wr.data;
  end

  cov_fifo_full: cover property (@(posedge clk) disable iff (rst) full);
endmodule
`default_nettype wire

// ---- chc_counter_core.sv ----
// Coulomb counting core: converter pulse counting, time bases, sleep control
// and the single-wire register link. Assumes a 10 MHz clock, analog compare
// results as pins, and an external pull-up on the host line.
//
// Summary of operation
// - Only one of discharge or charge accumulators counts, chosen by sense polarity.
// - Wake compare uses sense difference plus internal offset voltage.
// - Discharge polarity counts into a 16-bit discharge accumulator.
// - Charge polarity counts into a 16-bit charge accumulator.
// - Self-discharge accumulator advances once an hour at 25 degrees.
// - Self-discharge rate doubles per 10 degrees from the temperature sensor.
// - Discharge time counter ticks every 0.8789 s, or 225 s when slowed.
// - Charge time counter ticks every 0.8789 s, or 225 s when slowed.
// - Line high means normal counting; line low below threshold means sleep.
// - Supply is driven onto the backup pin while supply is good.
// - Register contents survive on backup power while main supply is low.
// - Device stores its measured offset; host can read it back.
// - Both parties only pull the host line low.
// - Returned bit cycles last 190 to 250 us.
// - Read answer starts 190 to 320 us after the command ends.
// - Low start of each returned bit lasts at least 32 us.
// - A long low is a break; host then idles high before commands.
// - Bytes travel as eight bits, least significant first.
// - Sleep after over 10 s low below threshold; wake on line high.
// - Command byte names a register, then write data or read back.
`timescale 1ns/1ns
`default_nettype none
module chc_counter_core
  import chc_pkg::*;
#(
  parameter chc_long_t SLEEP_CYC = CYC_SLEEP,
  parameter chc_long_t FAST_CYC  = CYC_FAST,
  parameter chc_long_t SLOW_CYC  = CYC_SLOW,
  parameter chc_long_t SD_CYC    = CYC_SD_BASE
) (
  // Clock and resets
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       nrstBackup,
  // Converter and analog front end
  input  wire logic       vfcPulse,
  input  wire logic       senseCharge,
  input  wire logic       wakeBelow,
  input  wire logic [2:0] tempStep,
  input  wire logic       supplyOk,
  // Offset calibration result
  input  wire logic [7:0] offsetMeas,
  input  wire logic       offsetLoad,
  // Single-wire host line
  input  wire logic       lineIn,
  output logic            lineOut,
  output logic            lineOe,
  // Backup and status
  output logic            backupDrive,
  output logic            sleeping
);

  logic [1:0] rstQ;
  logic [1:0] bkQ;
  logic       rst;
  logic       rstBk;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rstQ <= 2'h0;
    else rstQ <= {rstQ[0], 1'b1};
  end

  // Backup power loss is the only thing that wipes the counters
  always_ff @(posedge clk or negedge nrstBackup) begin
    if (!nrstBackup) bkQ <= 2'h0;
    else bkQ <= {bkQ[0], 1'b1};
  end

  assign rst   = ~rstQ[1];
  assign rstBk = ~bkQ[1];

  logic [7:0] pinRaw;
  logic [7:0] pinQ1;
  logic [7:0] pinQ2;
  logic       lineS;
  logic       supS;
  logic       belowS;
  logic       chargeS;
  logic       pulseS;
  logic [2:0] tempS;
  logic       pulseQ3;
  logic       linePrev;
  logic       pulseEdge;

  assign pinRaw = {tempStep, vfcPulse, senseCharge, wakeBelow, supplyOk, lineIn};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinQ1    <= SYNC_RST;
      pinQ2    <= SYNC_RST;
      pulseQ3  <= 1'b0;
      linePrev <= 1'b1;
    end else begin
      pinQ1    <= pinRaw;
      pinQ2    <= pinQ1;
      pulseQ3  <= pulseS;
      linePrev <= lineS;
    end
  end

  // Temperature bits may skew by a cycle; the sensor changes far slower
  assign lineS     = pinQ2[0];
  assign supS      = pinQ2[1];
  assign belowS    = pinQ2[2];
  assign chargeS   = pinQ2[3];
  assign pulseS    = pinQ2[4];
  assign tempS     = pinQ2[7:5];
  assign pulseEdge = pulseS && !pulseQ3;

  chc_pwr_e  pwr;
  chc_pwr_e  next_pwr;
  chc_long_t idleCnt;
  chc_long_t next_idleCnt;
  logic      counting;

  // The compare input already carries the offset-corrected sense level
  always_comb begin
    next_pwr     = pwr;
    next_idleCnt = LONG_ZERO;
    if (!lineS && belowS) begin
      next_idleCnt = (idleCnt > SLEEP_CYC) ? idleCnt : idleCnt + LONG_ONE;
    end
    unique case (pwr)
      PWR_NORMAL: if (idleCnt > SLEEP_CYC) next_pwr = PWR_SLEEP;
      PWR_SLEEP:  if (lineS) next_pwr = PWR_NORMAL;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr     <= PWR_NORMAL;
      idleCnt <= LONG_ZERO;
    end else begin
      pwr     <= next_pwr;
      idleCnt <= next_idleCnt;
    end
  end

  assign counting = (pwr == PWR_NORMAL);

  logic [15:0] acc [2];
  logic [15:0] next_acc [2];
  logic [15:0] tim [2];
  logic [15:0] next_tim [2];
  chc_long_t   pre [2];
  chc_long_t   next_pre [2];
  chc_long_t   period [2];
  logic [1:0]  dirOn;
  logic [15:0] sdAcc;
  logic [15:0] next_sdAcc;
  chc_long_t   sdPre;
  chc_long_t   next_sdPre;
  chc_long_t   sdPeriod;
  logic [7:0]  offsetReg;
  logic [7:0]  next_offset;
  logic [1:0]  modeReg;
  logic [1:0]  next_mode;
  logic        modeWr;
  logic [7:0]  cmdData;

  for (genvar g = 0; g < 2; g++) begin : g_dir
    assign dirOn[g]  = counting && (chargeS == (g == DIR_CHG));
    assign period[g] = modeReg[g] ? SLOW_CYC : FAST_CYC;
  end

  assign sdPeriod = SD_CYC >> tempS;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_acc[i] = acc[i];
      next_tim[i] = tim[i];
      next_pre[i] = pre[i];
      if (dirOn[i] && pulseEdge) next_acc[i] = acc[i] + 16'h0001;
      if (dirOn[i]) begin
        if (pre[i] >= period[i] - LONG_ONE) begin
          next_pre[i] = LONG_ZERO;
          next_tim[i] = tim[i] + 16'h0001;
        end else begin
          next_pre[i] = pre[i] + LONG_ONE;
        end
      end
    end
    next_sdAcc = sdAcc;
    next_sdPre = sdPre;
    if (counting) begin
      if (sdPre >= sdPeriod - LONG_ONE) begin
        next_sdPre = LONG_ZERO;
        next_sdAcc = sdAcc + 16'h0001;
      end else begin
        next_sdPre = sdPre + LONG_ONE;
      end
    end
    next_offset = offsetLoad ? offsetMeas : offsetReg;
    next_mode   = modeWr ? cmdData[1:0] : modeReg;
  end

  // Kept on backup power: only the backup reset clears these
  always_ff @(posedge clk or posedge rstBk) begin
    if (rstBk) begin
      for (int i = 0; i < 2; i++) begin
        acc[i] <= RST_WORD;
        tim[i] <= RST_WORD;
        pre[i] <= LONG_ZERO;
      end
      sdAcc     <= RST_WORD;
      sdPre     <= LONG_ZERO;
      offsetReg <= RST_BYTE;
      modeReg   <= 2'h0;
    end else begin
      acc       <= next_acc;
      tim       <= next_tim;
      pre       <= next_pre;
      sdAcc     <= next_sdAcc;
      sdPre     <= next_sdPre;
      offsetReg <= next_offset;
      modeReg   <= next_mode;
    end
  end

  chc_stream_if #(.W(8)) rxIf ();
  chc_stream_if #(.W(8)) cmdIf ();

  logic [11:0] lowCnt;
  logic [11:0] next_lowCnt;
  logic [7:0]  rxShift;
  logic [7:0]  next_rxShift;
  logic [2:0]  rxIdx;
  logic [2:0]  next_rxIdx;
  logic        rxValid;
  logic        next_rxValid;
  logic        brk;
  logic        txBusy;
  logic        rise;

  assign rise = lineS && !linePrev && !txBusy;

  always_comb begin
    next_lowCnt  = lineS ? 12'h000 : lowCnt;
    next_rxShift = rxShift;
    next_rxIdx   = rxIdx;
    next_rxValid = rxValid && !rxIf.ready;
    brk          = 1'b0;
    if (!lineS && lowCnt < CYC_BREAK) next_lowCnt = lowCnt + 12'h001;
    // A finished byte that the full FIFO cannot take stalls the receiver; bits arriving then are dropped
    if (rise && !next_rxValid) begin
      if (lowCnt >= CYC_BREAK) begin
        brk        = 1'b1;
        next_rxIdx = 3'h0;
      end else begin
        next_rxShift = {(lowCnt < CYC_SAMPLE), rxShift[7:1]};
        next_rxIdx   = rxIdx + 3'h1;
        if (rxIdx == 3'h7) next_rxValid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowCnt  <= 12'h000;
      rxShift <= RST_BYTE;
      rxIdx   <= 3'h0;
      rxValid <= 1'b0;
    end else begin
      lowCnt  <= next_lowCnt;
      rxShift <= next_rxShift;
      rxIdx   <= next_rxIdx;
      rxValid <= next_rxValid;
    end
  end

  assign rxIf.data  = rxShift;
  assign rxIf.valid = rxValid;

  chc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk (clk),
    .rst (rst),
    .wr  (rxIf),
    .rd  (cmdIf)
  );

  chc_tx_e     txState;
  chc_tx_e     next_txState;
  logic [11:0] txCnt;
  logic [11:0] next_txCnt;
  logic [2:0]  txBit;
  logic [2:0]  next_txBit;
  logic [7:0]  txByte;
  logic [7:0]  next_txByte;
  logic        haveCmd;
  logic        next_haveCmd;
  logic [6:0]  cmdAddr;
  logic [6:0]  next_cmdAddr;
  logic        next_oe;
  logic        pop;
  logic [6:0]  rdAddr;
  logic [7:0]  rdByte;
  logic [15:0] words [NUM_WORDS];

  assign words       = '{acc[DIR_DCH], acc[DIR_CHG], sdAcc, tim[DIR_DCH], tim[DIR_CHG]};
  assign txBusy      = (txState != TX_IDLE);
  assign cmdIf.ready = !txBusy;
  assign pop         = cmdIf.valid && cmdIf.ready;
  assign cmdData     = cmdIf.data;
  assign rdAddr      = cmdData[6:0];
  assign modeWr      = pop && haveCmd && !brk && (cmdAddr == ADDR_MODE);

  always_comb begin
    rdByte = RST_BYTE;
    if (rdAddr < ADDR_OFFSET) begin
      rdByte = rdAddr[0] ? words[rdAddr[3:1]][15:8] : words[rdAddr[3:1]][7:0];
    end else if (rdAddr == ADDR_OFFSET) begin
      rdByte = offsetReg;
    end else if (rdAddr == ADDR_MODE) begin
      rdByte = {6'h00, modeReg};
    end
  end

  always_comb begin
    next_txState = txState;
    next_txCnt   = txCnt + 12'h001;
    next_txBit   = txBit;
    next_txByte  = txByte;
    next_haveCmd = haveCmd;
    next_cmdAddr = cmdAddr;
    if (brk) begin
      next_haveCmd = 1'b0;
    end else if (pop) begin
      if (haveCmd) begin
        next_haveCmd = 1'b0;
      end else if (cmdData[CMD_WRITE_BIT]) begin
        next_haveCmd = 1'b1;
        next_cmdAddr = rdAddr;
      end else begin
        next_txByte  = rdByte;
        next_txState = TX_WAIT;
        next_txCnt   = 12'h000;
      end
    end
    unique case (txState)
      TX_IDLE: next_txBit = 3'h0;
      TX_WAIT: begin
        if (txCnt == CYC_RSP - 12'h001) begin
          next_txState = TX_BIT;
          next_txCnt   = 12'h000;
        end
      end
      TX_BIT: begin
        if (txCnt == CYC_BIT - 12'h001) begin
          next_txCnt = 12'h000;
          next_txBit = txBit + 3'h1;
          if (txBit == 3'h7) next_txState = TX_IDLE;
        end
      end
      default: next_txState = TX_IDLE;
    endcase
    // Ones release after the start, zeros hold until the data window ends
    next_oe = (txState == TX_BIT) &&
              (txCnt < (txByte[txBit] ? CYC_START : CYC_ZERO));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txState     <= TX_IDLE;
      txCnt       <= 12'h000;
      txBit       <= 3'h0;
      txByte      <= RST_BYTE;
      haveCmd     <= 1'b0;
      cmdAddr     <= 7'h00;
      lineOe      <= 1'b0;
      backupDrive <= 1'b0;
    end else begin
      txState     <= next_txState;
      txCnt       <= next_txCnt;
      txBit       <= next_txBit;
      txByte      <= next_txByte;
      haveCmd     <= next_haveCmd;
      cmdAddr     <= next_cmdAddr;
      lineOe      <= next_oe;
      backupDrive <= supS;
    end
  end

  assign lineOut  = 1'b0;
  assign sleeping = (pwr == PWR_SLEEP);

  logic [11:0] oeLen;
  logic [11:0] riseGap;
  logic [11:0] sinceCmd;
  logic        oePrev;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oeLen    <= 12'h000;
      riseGap  <= 12'h000;
      sinceCmd <= 12'h000;
      oePrev   <= 1'b0;
    end else begin
      oePrev   <= lineOe;
      oeLen    <= lineOe ? oeLen + 12'h001 : 12'h000;
      riseGap  <= (lineOe && !oePrev) ? 12'h001 :
                  (riseGap == 12'hFFF) ? riseGap : riseGap + 12'h001;
      sinceCmd <= (rxValid && lowCnt == 12'h000 && rxIdx == 3'h0 && !rxIf.ready) ? sinceCmd :
                  (next_rxValid && !rxValid) ? 12'h000 :
                  (sinceCmd == 12'hFFF) ? sinceCmd : sinceCmd + 12'h001;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst || rstBk);

  chk_one_direction: assert property (pulseEdge && counting |=>
    ((acc[0] != $past(acc[0])) != (acc[1] != $past(acc[1]))))
    else $error("pulse moved both or neither accumulator");
  chk_pulse_exact: assert property (pulseEdge && counting |=>
    (16'(acc[0] + acc[1]) == 16'($past(acc[0]) + $past(acc[1]) + 16'h0001)))
    else $error("pulse not counted exactly once");
  chk_discharge_acc: assert property (pulseEdge && counting && !chargeS |=>
    acc[DIR_DCH] == $past(acc[DIR_DCH]) + 16'h0001)
    else $error("discharge pulse missed");
  chk_charge_acc: assert property (pulseEdge && counting && chargeS |=>
    acc[DIR_CHG] == $past(acc[DIR_CHG]) + 16'h0001)
    else $error("charge pulse missed");
  chk_sleep_frozen: assert property (sleeping |=>
    $stable(acc[0]) && $stable(acc[1]) && $stable(sdAcc))
    else $error("counting during sleep");
  chk_sleep_entry: assert property ($rose(sleeping) |->
    $past(idleCnt) > SLEEP_CYC && !$past(lineS, 2))
    else $error("sleep entered too early");
  chk_wake_exit: assert property (sleeping && lineS |=> !sleeping)
    else $error("no wake on line high");
  chk_start_hold: assert property ($fell(lineOe) |-> oeLen >= CYC_STRB_MIN)
    else $error("bit start too short");
  chk_bit_cycle: assert property ($rose(lineOe) && txBit != 3'h0 |->
    riseGap >= CYC_CYC_MIN && riseGap <= CYC_CYC_MAX)
    else $error("returned bit cycle out of range");
  chk_rsp_window: assert property ($rose(txState == TX_BIT) |->
    sinceCmd >= CYC_RSP_MIN && sinceCmd <= CYC_RSP_MAX)
    else $error("read answer outside window");
  chk_backup_follow: assert property (supS |=> backupDrive)
    else $error("backup pin not driven");
  chk_offset_store: assert property (offsetLoad |=> offsetReg == $past(offsetMeas))
    else $error("offset not stored");

  cov_sleep: cover property ($rose(sleeping));
  cov_read: cover property ($rose(txState == TX_BIT));
  cov_break: cover property (brk);
endmodule
`default_nettype wire

// ---- chc_host_model.sv ----
// Host side of the single-wire link: sends bytes, breaks and reads.
// Assumes the bench wires the line as a pulled-up open-drain node.
`timescale 1ns/1ns
`default_nettype none
module chc_host_model (
  // Clock and wired line level
  input  wire logic clk,
  input  wire logic lineLvl,
  // High while the host pulls the line low
  output logic      hostPull
);
  int lastHi;

  initial begin
    hostPull = 1'b0;
    lastHi = 0;
  end

  // Host only ever pulls low; release lets the pull-up win
  task automatic hold(input int lowCyc, input int hiCyc);
    hostPull <= 1'b1;
    repeat (lowCyc) @(posedge clk);
    hostPull <= 1'b0;
    repeat (hiCyc) @(posedge clk);
    lastHi = hiCyc;
  endtask

  // Every bit cycle lasts 1900 cycles, the shortest allowed
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) hold(b[i] ? 300 : 1300, b[i] ? 1600 : 600);
  endtask

  // Reads one register and reports the device's own line timing
  task automatic read_byte(input logic [7:0] cmd, output logic [7:0] val, output int rsp,
                           output int lowMin, output int perMin, output int perMax);
    int lowC;
    int hiC;
    send_byte(cmd);
    for (rsp = lastHi; lineLvl !== 1'b0 && rsp < 4000; rsp++) @(posedge clk);
    lowMin = 9999;
    perMin = 9999;
    perMax = 0;
    for (int i = 0; i < 8; i++) begin
      for (lowC = 0; lineLvl === 1'b0 && lowC < 3000; lowC++) @(posedge clk);
      for (hiC = 0; lineLvl !== 1'b0 && hiC < 1700; hiC++) @(posedge clk);
      val[i] = (lowC < 1000);
      lowMin = (lowC < lowMin) ? lowC : lowMin;
      if (i < 7) begin
        perMin = (lowC + hiC < perMin) ? lowC + hiC : perMin;
        perMax = (lowC + hiC > perMax) ? lowC + hiC : perMax;
      end
    end
  endtask
endmodule
`default_nettype wire

// ---- chc_counter_core_tb.sv ----
// Self-checking bench for the counter core with a host model on the line.
// Assumes an external pull-up, so the line is high unless someone pulls it.
`timescale 1ns/1ns
`default_nettype none
module chc_counter_core_tb;
  import chc_pkg::*;
  logic       clk, nrst, nrstBackup, vfcPulse, senseCharge, wakeBelow;
  logic       supplyOk, offsetLoad, lineOut, lineOe, backupDrive, sleeping;
  logic       hostPull;
  logic [2:0] tempStep;
  logic [7:0] offsetMeas, offs;
  wire logic  lineIn;
  int         bad_count, n_tests;
  int         cnt [2];

  // Bench tick periods in cycles; the rate window is a multiple of every one of them
  localparam int FAST_T   = 20;
  localparam int SD_HOUR  = 48;
  localparam int RATE_WIN = 1920;

  assign lineIn = ~(hostPull | lineOe);

  chc_counter_core #(
    .SLEEP_CYC(40'h00_0000_0032), .FAST_CYC(40'h00_0000_0014),
    .SLOW_CYC(40'h00_0000_003C), .SD_CYC(40'h00_0000_0180)
  ) dut_u (
    .clk(clk), .nrst(nrst), .nrstBackup(nrstBackup), .vfcPulse(vfcPulse),
    .senseCharge(senseCharge), .wakeBelow(wakeBelow), .tempStep(tempStep),
    .supplyOk(supplyOk), .offsetMeas(offsetMeas), .offsetLoad(offsetLoad),
    .lineIn(lineIn), .lineOut(lineOut), .lineOe(lineOe),
    .backupDrive(backupDrive), .sleeping(sleeping)
  );

  chc_host_model host_u (.clk(clk), .lineLvl(lineIn), .hostPull(hostPull));

  always #50 clk = ~clk;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Reference count follows only pulses the device should see
  task automatic pulses(input logic dir, input int n, input bit live);
    senseCharge <= dir;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      vfcPulse <= 1'b1;
      repeat (3) @(posedge clk);
      vfcPulse <= 1'b0;
      repeat (3) @(posedge clk);
      if (live) cnt[dir]++;
    end
  endtask

  // Tick counts over a fixed window do not depend on where the prescalers stand
  task automatic rates(input logic dir, input logic [2:0] t);
    logic [15:0] s0, d0, o0;
    senseCharge <= dir;
    tempStep <= t;
    repeat (4) @(posedge clk);
    s0 = dut_u.sdAcc;
    d0 = dut_u.tim[dir];
    o0 = dut_u.tim[!dir];
    repeat (RATE_WIN) @(posedge clk);
    check("self-discharge ticks", ((RATE_WIN / SD_HOUR) << t) >> 3, 16'(dut_u.sdAcc - s0));
    check("active time ticks", RATE_WIN / FAST_T, 16'(dut_u.tim[dir] - d0));
    check("idle time ticks", 0, 16'(dut_u.tim[!dir] - o0));
    $display("test rates done");
  endtask

  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] v;
    int         rsp, lowMin, perMin, perMax;
    host_u.read_byte(cmd, v, rsp, lowMin, perMin, perMax);
    check("read data", exp, v);
    check("response delay", 1, rsp >= CYC_RSP_MIN && rsp <= CYC_RSP_MAX);
    check("start hold", 1, lowMin >= CYC_STRB_MIN);
    check("bit period", 1, perMin >= CYC_CYC_MIN && perMax <= CYC_CYC_MAX);
    $display("test read %0h done", cmd);
  endtask

  // Three reads of about 35k cycles each dominate, some 113k in all
  initial begin
    #13_000_000;
    bad_count++;
    complete_run();
  end

  initial begin
    clk = 1'b0;
    {nrst, nrstBackup, vfcPulse, senseCharge, wakeBelow, supplyOk, offsetLoad} = '0;
    tempStep = 3'h3;
    offsetMeas = 8'h00;
    cnt = '{0, 0};
    bad_count = 0;
    n_tests = 0;
    void'($urandom(32'h52c7));
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    nrstBackup <= 1'b1;
    repeat (6) @(posedge clk);
    check("idle line drive", 0, {lineOe, lineOut, sleeping});
    for (int i = 0; i < 4; i++) begin
      supplyOk <= i[0];
      repeat (6) @(posedge clk);
      check("backupDrive", i[0], backupDrive);
    end
    rates(1'($urandom), 3'($urandom));
    offs = 8'($urandom);
    offsetMeas <= offs;
    offsetLoad <= 1'b1;
    @(posedge clk);
    offsetLoad <= 1'b0;
    for (int g = 0; g < 4; g++) pulses(g[0], 1 + $urandom % 20, 1);
    $display("test counting done");
    // A long low is also a break; it clears any half-received command
    fork
      host_u.hold(2000, 400);
      begin
        repeat (200) @(posedge clk);
        check("normal with line low", 0, sleeping);
        pulses(1, 1 + $urandom % 20, 1);
      end
    join
    wakeBelow <= 1'b1;
    fork
      host_u.hold(2000, 400);
      begin
        repeat (200) @(posedge clk);
        check("sleep entry", 1, sleeping);
        pulses(0, 1 + $urandom % 20, 0);
      end
    join
    check("wake on line high", 0, sleeping);
    wakeBelow <= 1'b0;
    $display("test sleep done");
    // Main reset in mid-run must leave counters and offset alone
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h00, 8'(cnt[DIR_DCH]));
    rd(8'h02, 8'(cnt[DIR_CHG]));
    rd({1'b0, ADDR_OFFSET}, offs);
    complete_run();
  end
endmodule
`default_nettype wire
